// >>> common/ofe_pkg.sv
package ofe_pkg;

	// ****************************************
	// bus and register map
	// ****************************************
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [7:0] OFS_GAIN = 8'h00;
	localparam logic [7:0] OFS_TRIM = 8'h04;
	localparam logic [7:0] OFS_MONFILT = 8'h08;
	localparam logic [7:0] OFS_POWER = 8'h0C;
	localparam logic [7:0] OFS_BYPASS = 8'h10;
	localparam logic [7:0] OFS_LF_CTRL = 8'h14;
	localparam logic [7:0] OFS_CLK_CTRL = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_FOCUS_ERR = 8'h20;
	localparam logic [7:0] OFS_RADIAL_ERR = 8'h24;
	localparam logic [7:0] OFS_SAT_ERR = 8'h28;

	// ****************************************
	// field positions
	// ****************************************
	localparam int STATIC_GAIN_MSB = 7;
	localparam int STATIC_GAIN_LSB = 4;
	localparam int DYN_GAIN_MSB = 3;
	localparam int DYN_GAIN_LSB = 0;
	localparam int TRIM_MSB = 5;
	localparam int TRIM_LSB = 0;
	localparam int MON_SEL_MSB = 6;
	localparam int MON_SEL_LSB = 4;
	localparam int ROLLOFF_MSB = 3;
	localparam int ROLLOFF_LSB = 0;
	localparam int POWER_MSB = 5;
	localparam int POWER_LSB = 0;
	localparam int BYPASS_BIT = 1;
	localparam int SUM_THREE_BIT = 0;
	localparam int LF_GAIN_MSB = 3;
	localparam int LF_GAIN_LSB = 0;
	localparam int AUX_SEL_BIT = 4;
	localparam int LASER_ON_BIT = 5;
	localparam int CRYSTAL_SIXTEEN_SELECT_BIT = 0;
	localparam int SYSCLK_EN_BIT = 1;
	localparam int STAT_HF_LSB = 8;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_GAIN = 8'h00;
	localparam logic [7:0] RST_TRIM = 8'h00;
	localparam logic [7:0] RST_MONFILT = 8'h00;
	localparam logic [7:0] RST_POWER = 8'h3F;
	localparam logic [7:0] RST_BYPASS = 8'h00;
	localparam logic [7:0] RST_LF_CTRL = 8'h00;
	localparam logic [7:0] RST_CLK_CTRL = 8'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int PDM_HZ = 4_000_000;
	localparam int PHASE_UNIT_HZ = 100_000;
	localparam int LF_WINDOW = 64;
	localparam int NUM_LF_CH = 8;

endpackage : ofe_pkg

// >>> core/lf_channel.sv
`timescale 1ns/1ns

module lf_channel #(
	parameter int WINDOW = 64
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converter stream
	input wire logic sample_en,
	input wire logic pdm_bit,
	input wire logic laser_on,
	// filtered result
	output logic signed [$clog2(WINDOW)+2:0] value,
	output logic offset_valid
);

	localparam int CW = $clog2(WINDOW);
	localparam int VW = CW + 3;

	logic [CW-1:0] cnt_r;
	logic [CW:0] ones_r;
	logic [CW:0] total;
	logic signed [CW+1:0] avg_r;
	logic signed [CW+1:0] offset_r;
	logic done_r;
	logic valid_r;
	logic signed [VW-1:0] value_r;

	assign total = ones_r + (CW+1)'(pdm_bit);
	assign value = value_r;
	assign offset_valid = valid_r;

	// ****************************************
	// low-pass: ones count over a window
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			ones_r <= '0;
			avg_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (sample_en) begin
				if (cnt_r == CW'(WINDOW - 1)) begin
					cnt_r <= '0;
					ones_r <= '0;
					// 2*ones - window: zero for a half-density stream
					avg_r <= (CW+2)'({total, 1'b0}) - (CW+2)'(WINDOW);
					done_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 1'b1;
					ones_r <= total;
				end
			end
		end
	end

	// ****************************************
	// offset capture and subtraction
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			offset_r <= '0;
			valid_r <= 1'b0;
		end else if (done_r && !laser_on) begin
			offset_r <= avg_r;
			valid_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_r <= '0;
		end else if (done_r) begin
			if (laser_on) begin
				value_r <= VW'(avg_r) - VW'(offset_r);
			end else begin
				value_r <= VW'(avg_r);
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_offset_capture: assert property (done_r && !laser_on |=> offset_r == $past(avg_r))
		else $error("offset not captured while laser off");
	a_offset_subtract: assert property (done_r && laser_on |=> value_r == VW'($past(avg_r)) - VW'($past(offset_r)))
		else $error("offset not subtracted while laser on");
	a_window_result: assert property (sample_en && cnt_r == CW'(WINDOW - 1) |=> done_r && avg_r == (CW+2)'({$past(total), 1'b0}) - (CW+2)'(WINDOW))
		else $error("filter window result wrong");

endmodule : lf_channel

// >>> core/optical_frontend_control.sv
`timescale 1ns/1ns

// How it works
// - each photodiode converter stream is sampled at a 4 MHz enable rate
// - focus, radial and satellite difference signals are formed from channel pairs
// - dc level captured with laser off, subtracted from stream with laser on
// - lf gain setting drives converter; windowed low-pass averages each stream
// - aux select steers first two converters; general inputs own dedicated channels
// - gain register bits 7:4 drive first amplifier static gain
// - gain register bits 3:0 drive second amplifier dynamic gain, rewritable anytime
// - offset trim bits 5:0 drive the sign-magnitude offset dac
// - control one bits 6:4 select the eye monitor node
// - control one low bits set the noise filter roll-off
// - control two bits 5:0 are individual hf power-down controls
// - bypass bit 1 feeds the hf converter from the monitor pin
// - hf signal sums three or four diodes, captured as six bits
// - sixteen megahertz select enables the crystal divide-by-2
// - system clock sources both decoder and processor clock generators
module optical_frontend_control #(
	parameter int WINDOW = ofe_pkg::LF_WINDOW,
	parameter int NCH = ofe_pkg::NUM_LF_CH
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [ofe_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [ofe_pkg::AXI_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [ofe_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [ofe_pkg::AXI_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// converter pins
	input wire logic [NCH-1:0] pdm_in,
	input wire logic [5:0] hf_sample,
	// lf path controls
	output logic [3:0] lf_converter_gain_setting,
	output logic aux_input_select,
	output logic laser_on,
	// hf path controls
	output logic [3:0] first_stage_static_gain,
	output logic [3:0] second_stage_dynamic_gain,
	output logic [5:0] offset_trim_value,
	output logic [2:0] eye_monitor_select,
	output logic [3:0] noise_filter_rolloff,
	output logic [5:0] hf_power_down,
	output logic hf_input_from_monitor,
	output logic hf_sum_three_select,
	// clock controls
	output logic crystal_divide_enable,
	output logic decoder_clock_source,
	output logic cpu_clock_source,
	// servo error signals
	output logic signed [$clog2(WINDOW)+3:0] focus_error,
	output logic signed [$clog2(WINDOW)+3:0] radial_error,
	output logic signed [$clog2(WINDOW)+3:0] satellite_error
);

	localparam int VW = $clog2(WINDOW) + 3;
	localparam int DW = VW + 1;
	localparam logic [7:0] PHASE_STEP = 8'(ofe_pkg::PDM_HZ / ofe_pkg::PHASE_UNIT_HZ);
	localparam logic [7:0] PHASE_MOD = 8'(ofe_pkg::CLK_HZ / ofe_pkg::PHASE_UNIT_HZ);

	// ****************************************
	// declarations
	// ****************************************
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_en;
	logic wr_byte;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_word;

	logic [7:0] gain_r;
	logic [7:0] trim_r;
	logic [7:0] monfilt_r;
	logic [7:0] power_r;
	logic [7:0] bypass_r;
	logic [7:0] lf_ctrl_r;
	logic [7:0] clk_ctrl_r;

	logic [NCH-1:0] pdm_s1_r;
	logic [NCH-1:0] pdm_s2_r;
	logic [5:0] hf_s1_r;
	logic [5:0] hf_s2_r;
	logic [5:0] hf_data_r;
	logic [7:0] phase_r;
	logic [7:0] phase_nxt;
	logic sample_en_r;
	logic signed [VW-1:0] ch_val [NCH];
	logic [NCH-1:0] ch_valid;
	logic signed [DW-1:0] focus_r;
	logic signed [DW-1:0] radial_r;
	logic signed [DW-1:0] sat_r;

	// ****************************************
	// axi4-lite write channels
	// ****************************************
	assign wr_en = aw_held_r && w_held_r && !bvalid_r;
	assign wr_byte = wr_en && wstrb_r[0];

	always_comb begin
		case (waddr_r)
			ofe_pkg::OFS_GAIN, ofe_pkg::OFS_TRIM, ofe_pkg::OFS_MONFILT, ofe_pkg::OFS_POWER,
			ofe_pkg::OFS_BYPASS, ofe_pkg::OFS_LF_CTRL, ofe_pkg::OFS_CLK_CTRL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			aw_held_r <= 1'b0;
			waddr_r <= 8'h00;
		end else if (awvalid && awready_r) begin
			waddr_r <= awaddr;
			aw_held_r <= 1'b1;
			awready_r <= 1'b0;
		end else if (bvalid_r && bready) begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b1;
			w_held_r <= 1'b0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else if (wvalid && wready_r) begin
			wdata_r <= wdata;
			wstrb_r <= wstrb;
			w_held_r <= 1'b1;
			wready_r <= 1'b0;
		end else if (bvalid_r && bready) begin
			w_held_r <= 1'b0;
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= ofe_pkg::RESP_OKAY;
		end else if (wr_en) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? ofe_pkg::RESP_OKAY : ofe_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gain_r <= ofe_pkg::RST_GAIN;
			trim_r <= ofe_pkg::RST_TRIM;
			monfilt_r <= ofe_pkg::RST_MONFILT;
			power_r <= ofe_pkg::RST_POWER;
			bypass_r <= ofe_pkg::RST_BYPASS;
			lf_ctrl_r <= ofe_pkg::RST_LF_CTRL;
			clk_ctrl_r <= ofe_pkg::RST_CLK_CTRL;
		end else if (wr_byte) begin
			// values held until the next write
			case (waddr_r)
				ofe_pkg::OFS_GAIN: gain_r <= wdata_r[7:0];
				ofe_pkg::OFS_TRIM: trim_r <= wdata_r[7:0];
				ofe_pkg::OFS_MONFILT: monfilt_r <= wdata_r[7:0];
				ofe_pkg::OFS_POWER: power_r <= wdata_r[7:0];
				ofe_pkg::OFS_BYPASS: bypass_r <= wdata_r[7:0];
				ofe_pkg::OFS_LF_CTRL: lf_ctrl_r <= wdata_r[7:0];
				ofe_pkg::OFS_CLK_CTRL: clk_ctrl_r <= wdata_r[7:0];
				default: ;
			endcase
		end
	end

	assign first_stage_static_gain = gain_r[ofe_pkg::STATIC_GAIN_MSB:ofe_pkg::STATIC_GAIN_LSB];
	assign second_stage_dynamic_gain = gain_r[ofe_pkg::DYN_GAIN_MSB:ofe_pkg::DYN_GAIN_LSB];
	assign offset_trim_value = trim_r[ofe_pkg::TRIM_MSB:ofe_pkg::TRIM_LSB];
	assign eye_monitor_select = monfilt_r[ofe_pkg::MON_SEL_MSB:ofe_pkg::MON_SEL_LSB];
	assign noise_filter_rolloff = monfilt_r[ofe_pkg::ROLLOFF_MSB:ofe_pkg::ROLLOFF_LSB];
	assign hf_power_down = power_r[ofe_pkg::POWER_MSB:ofe_pkg::POWER_LSB];
	assign hf_input_from_monitor = bypass_r[ofe_pkg::BYPASS_BIT];
	assign hf_sum_three_select = bypass_r[ofe_pkg::SUM_THREE_BIT];
	assign lf_converter_gain_setting = lf_ctrl_r[ofe_pkg::LF_GAIN_MSB:ofe_pkg::LF_GAIN_LSB];
	assign aux_input_select = lf_ctrl_r[ofe_pkg::AUX_SEL_BIT];
	assign laser_on = lf_ctrl_r[ofe_pkg::LASER_ON_BIT];
	assign crystal_divide_enable = clk_ctrl_r[ofe_pkg::CRYSTAL_SIXTEEN_SELECT_BIT];
	// one system clock feeds both generators
	assign decoder_clock_source = clk_ctrl_r[ofe_pkg::SYSCLK_EN_BIT];
	assign cpu_clock_source = clk_ctrl_r[ofe_pkg::SYSCLK_EN_BIT];

	// ****************************************
	// axi4-lite read channels
	// ****************************************
	always_comb begin
		rd_hit = 1'b1;
		case (araddr)
			ofe_pkg::OFS_GAIN: rd_word = {24'h000000, gain_r};
			ofe_pkg::OFS_TRIM: rd_word = {24'h000000, trim_r};
			ofe_pkg::OFS_MONFILT: rd_word = {24'h000000, monfilt_r};
			ofe_pkg::OFS_POWER: rd_word = {24'h000000, power_r};
			ofe_pkg::OFS_BYPASS: rd_word = {24'h000000, bypass_r};
			ofe_pkg::OFS_LF_CTRL: rd_word = {24'h000000, lf_ctrl_r};
			ofe_pkg::OFS_CLK_CTRL: rd_word = {24'h000000, clk_ctrl_r};
			ofe_pkg::OFS_STATUS: rd_word = 32'({hf_data_r, 8'(ch_valid)});
			ofe_pkg::OFS_FOCUS_ERR: rd_word = 32'(focus_r);
			ofe_pkg::OFS_RADIAL_ERR: rd_word = 32'(radial_r);
			ofe_pkg::OFS_SAT_ERR: rd_word = 32'(sat_r);
			default: begin
				rd_word = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= ofe_pkg::RESP_OKAY;
			rdata_r <= 32'h00000000;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_hit ? ofe_pkg::RESP_OKAY : ofe_pkg::RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;

	// ****************************************
	// pin synchronisers and sample rate
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pdm_s1_r <= '0;
			pdm_s2_r <= '0;
			hf_s1_r <= 6'h00;
			hf_s2_r <= 6'h00;
			hf_data_r <= 6'h00;
		end else begin
			pdm_s1_r <= pdm_in;
			pdm_s2_r <= pdm_s1_r;
			hf_s1_r <= hf_sample;
			hf_s2_r <= hf_s1_r;
			hf_data_r <= hf_s2_r;
		end
	end

	// fractional divider: 4 enables per 10 clocks
	assign phase_nxt = phase_r + PHASE_STEP;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_r <= 8'h00;
			sample_en_r <= 1'b0;
		end else if (phase_nxt >= PHASE_MOD) begin
			phase_r <= phase_nxt - PHASE_MOD;
			sample_en_r <= 1'b1;
		end else begin
			phase_r <= phase_nxt;
			sample_en_r <= 1'b0;
		end
	end

	// ****************************************
	// lf channels and servo differences
	// ****************************************
	// channels 0..5: central a-d, satellite a-b (0,1 carry aux when selected); 6,7: general inputs
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		lf_channel #(.WINDOW(WINDOW)) u_ch (
			.aclk(aclk),
			.aresetn(aresetn),
			.sample_en(sample_en_r),
			.pdm_bit(pdm_s2_r[i]),
			.laser_on(laser_on),
			.value(ch_val[i]),
			.offset_valid(ch_valid[i])
		);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			focus_r <= '0;
			radial_r <= '0;
			sat_r <= '0;
		end else begin
			focus_r <= DW'(ch_val[0]) - DW'(ch_val[1]);
			radial_r <= DW'(ch_val[2]) - DW'(ch_val[3]);
			sat_r <= DW'(ch_val[4]) - DW'(ch_val[5]);
		end
	end

	assign focus_error = focus_r;
	assign radial_error = radial_r;
	assign satellite_error = sat_r;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_gain_write;
		wr_byte && waddr_r == ofe_pkg::OFS_GAIN;
	endsequence
	sequence s_both_held;
		aw_held_r && w_held_r && !bvalid_r;
	endsequence

	a_sample_spacing: assert property (sample_en_r |=> !sample_en_r ##[1:2] sample_en_r)
		else $error("sample enable spacing wrong");
	a_focus_diff: assert property (##1 focus_error == DW'($past(ch_val[0])) - DW'($past(ch_val[1])))
		else $error("focus difference wrong");
	a_static_gain: assert property (s_gain_write |=> first_stage_static_gain == $past(wdata_r[7:4]))
		else $error("static gain not taken from bits 7:4");
	a_dynamic_gain: assert property (s_gain_write |=> second_stage_dynamic_gain == $past(wdata_r[3:0]))
		else $error("dynamic gain not taken from bits 3:0");
	a_trim_write: assert property (wr_byte && waddr_r == ofe_pkg::OFS_TRIM |=> offset_trim_value == $past(wdata_r[5:0]))
		else $error("offset trim not updated");
	a_monitor_select: assert property (wr_byte && waddr_r == ofe_pkg::OFS_MONFILT |=> eye_monitor_select == $past(wdata_r[6:4]))
		else $error("monitor select not updated");
	a_rolloff_write: assert property (wr_byte && waddr_r == ofe_pkg::OFS_MONFILT |=> noise_filter_rolloff == $past(wdata_r[3:0]))
		else $error("roll-off not updated");
	a_power_down: assert property (wr_byte && waddr_r == ofe_pkg::OFS_POWER |=> hf_power_down == $past(wdata_r[5:0]))
		else $error("power-down bits not updated");
	a_bypass_bit: assert property (wr_byte && waddr_r == ofe_pkg::OFS_BYPASS |=> hf_input_from_monitor == $past(wdata_r[1]))
		else $error("bypass not taken from bit 1");
	a_crystal_div: assert property (wr_byte && waddr_r == ofe_pkg::OFS_CLK_CTRL |=> crystal_divide_enable == $past(wdata_r[0]))
		else $error("divide-by-2 not following select");
	a_clock_sources: assert property (wr_byte && waddr_r == ofe_pkg::OFS_CLK_CTRL |=>
		decoder_clock_source == $past(wdata_r[1]) && cpu_clock_source == $past(wdata_r[1]))
		else $error("clock generators not on one source");
	a_fields_hold: assert property (!wr_byte |=> $stable(gain_r) && $stable(trim_r) && $stable(power_r))
		else $error("control field changed without write");
	a_write_resp: assert property (s_both_held |=> bvalid_r && (bresp_r == ofe_pkg::RESP_OKAY) == $past(wr_hit))
		else $error("write response missing or wrong");

endmodule : optical_frontend_control

// >>> verification/diode_array_model.sv
`timescale 1ns/1ns

// ****************************************
// photodiode array seen through its converters
// ****************************************
module diode_array_model #(
	parameter int NCH = 8
) (
	// clock
	input wire logic aclk,
	// scene
	input wire logic [NCH-1:0] level,
	input wire logic aux_select,
	input wire logic [1:0] aux_level,
	// converter streams
	output logic [NCH-1:0] pdm_in
);
	// full-scale streams only: density tracks the diode level
	always_ff @(posedge aclk) begin
		pdm_in <= aux_select ? {level[NCH-1:2], aux_level} : level;
	end
endmodule : diode_array_model

// >>> verification/optical_frontend_control_bench.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch at %0t got %h expected %h", $time, (got), (exp)); end end

module optical_frontend_control_bench;
	localparam int WIN = 8;
	localparam int WIN_CLK = WIN * 5 / 2;
	typedef struct {logic [7:0] addr; logic [7:0] data; logic [1:0] resp; logic [7:0] port;} row_s;
	localparam logic [7:0] RST_TAB [7] = '{ofe_pkg::RST_GAIN, ofe_pkg::RST_TRIM, ofe_pkg::RST_MONFILT,
		ofe_pkg::RST_POWER, ofe_pkg::RST_BYPASS, ofe_pkg::RST_LF_CTRL, ofe_pkg::RST_CLK_CTRL};
	localparam logic [7:0] ADR_TAB [7] = '{ofe_pkg::OFS_GAIN, ofe_pkg::OFS_TRIM, ofe_pkg::OFS_MONFILT,
		ofe_pkg::OFS_POWER, ofe_pkg::OFS_BYPASS, ofe_pkg::OFS_LF_CTRL, ofe_pkg::OFS_CLK_CTRL};
	// ****************************************
	// register cases: address, data, response, port image
	// ****************************************
	row_s rows [9] = '{
		'{ofe_pkg::OFS_GAIN, 8'hA5, ofe_pkg::RESP_OKAY, 8'hA5},
		'{ofe_pkg::OFS_TRIM, 8'h2B, ofe_pkg::RESP_OKAY, 8'h2B},
		'{ofe_pkg::OFS_MONFILT, 8'h5C, ofe_pkg::RESP_OKAY, 8'h5C},
		'{ofe_pkg::OFS_POWER, 8'h15, ofe_pkg::RESP_OKAY, 8'h15},
		'{ofe_pkg::OFS_BYPASS, 8'h03, ofe_pkg::RESP_OKAY, 8'h03},
		'{ofe_pkg::OFS_LF_CTRL, 8'h1A, ofe_pkg::RESP_OKAY, 8'h1A},
		'{ofe_pkg::OFS_CLK_CTRL, 8'h03, ofe_pkg::RESP_OKAY, 8'h03},
		'{ofe_pkg::OFS_STATUS, 8'h77, ofe_pkg::RESP_SLVERR, 8'h00},
		'{8'h2C, 8'h77, ofe_pkg::RESP_SLVERR, 8'h00}
	};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [5:0] hf_sample = 6'h2D;
	logic [7:0] level = 8'h79;
	logic [1:0] aux_level = 2'b10;
	logic awready, wready, bvalid, arready, rvalid, aux_input_select, laser_on;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [7:0] pdm_in;
	logic [3:0] lf_converter_gain_setting, first_stage_static_gain, second_stage_dynamic_gain, noise_filter_rolloff;
	logic [5:0] offset_trim_value, hf_power_down;
	logic [2:0] eye_monitor_select;
	logic hf_input_from_monitor, hf_sum_three_select, crystal_divide_enable, decoder_clock_source, cpu_clock_source;
	logic [6:0] focus_error, radial_error, satellite_error;
	int errors = 0;
	int cmp_count = 0;

	always #50 aclk = ~aclk;

	diode_array_model #(.NCH(8)) u_diodes (.aclk(aclk), .level(level), .aux_select(aux_input_select),
		.aux_level(aux_level), .pdm_in(pdm_in));

	optical_frontend_control #(.WINDOW(WIN), .NCH(8)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .pdm_in(pdm_in), .hf_sample(hf_sample),
		.lf_converter_gain_setting(lf_converter_gain_setting), .aux_input_select(aux_input_select),
		.laser_on(laser_on), .first_stage_static_gain(first_stage_static_gain),
		.second_stage_dynamic_gain(second_stage_dynamic_gain), .offset_trim_value(offset_trim_value),
		.eye_monitor_select(eye_monitor_select), .noise_filter_rolloff(noise_filter_rolloff),
		.hf_power_down(hf_power_down), .hf_input_from_monitor(hf_input_from_monitor),
		.hf_sum_three_select(hf_sum_three_select), .crystal_divide_enable(crystal_divide_enable),
		.decoder_clock_source(decoder_clock_source), .cpu_clock_source(cpu_clock_source),
		.focus_error(focus_error), .radial_error(radial_error), .satellite_error(satellite_error));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] port_of(input logic [7:0] a);
		case (a)
			ofe_pkg::OFS_GAIN: return {first_stage_static_gain, second_stage_dynamic_gain};
			ofe_pkg::OFS_TRIM: return {2'h0, offset_trim_value};
			ofe_pkg::OFS_MONFILT: return {1'b0, eye_monitor_select, noise_filter_rolloff};
			ofe_pkg::OFS_POWER: return {2'h0, hf_power_down};
			ofe_pkg::OFS_BYPASS: return {6'h00, hf_input_from_monitor, hf_sum_three_select};
			ofe_pkg::OFS_LF_CTRL: return {2'h0, laser_on, aux_input_select, lf_converter_gain_setting};
			ofe_pkg::OFS_CLK_CTRL: return {6'h00, decoder_clock_source, crystal_divide_enable};
			default: return 8'h00;
		endcase
	endfunction : port_of

	task automatic close_out();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset

	task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
		bit aw_ok, w_ok;
		int n;
		aw_ok = 0;
		w_ok = 0;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (aw_ok && w_ok && bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			if (awready && !aw_ok) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (wready && !w_ok) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		if (n == 40) begin
			errors++;
			close_out();
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ar_ok;
		int n;
		ar_ok = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (ar_ok && rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
			if (arready && !ar_ok) begin
				ar_ok = 1;
				arvalid <= 1'b0;
			end
		end
		if (n == 40) begin
			errors++;
			close_out();
		end
	endtask : axi_read

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		do_reset();
		for (int i = 0; i < 9; i++) begin
			axi_write(rows[i].addr, rows[i].data, 4'hF, resp);
			`CHK(resp, rows[i].resp)
			if (rows[i].resp === ofe_pkg::RESP_OKAY) begin
				axi_read(rows[i].addr, rd, resp);
				`CHK(rd, {24'h0, rows[i].data})
				`CHK(port_of(rows[i].addr), rows[i].port)
			end
		end
		`CHK(crystal_divide_enable, 1'b1)
		`CHK(cpu_clock_source, 1'b1)
		// strobe off stores nothing
		axi_write(ofe_pkg::OFS_GAIN, 8'h33, 4'h0, resp);
		`CHK(resp, ofe_pkg::RESP_OKAY)
		`CHK(port_of(ofe_pkg::OFS_GAIN), 8'hA5)
		// back-to-back gain rewrites
		axi_write(ofe_pkg::OFS_GAIN, 8'hA7, 4'hF, resp);
		axi_write(ofe_pkg::OFS_GAIN, 8'hA9, 4'hF, resp);
		`CHK(second_stage_dynamic_gain, 4'h9)
		`CHK(first_stage_static_gain, 4'hA)
		axi_read(8'h2C, rd, resp);
		`CHK({resp, rd}, {ofe_pkg::RESP_SLVERR, 32'h0})
		// laser off: offsets captured, raw differences shown
		axi_write(ofe_pkg::OFS_LF_CTRL, 8'h00, 4'hF, resp);
		repeat (6 * WIN_CLK) @(posedge aclk);
		axi_read(ofe_pkg::OFS_STATUS, rd, resp);
		`CHK(rd[7:0], 8'hFF)
		`CHK(rd[13:8], 6'h2D)
		`CHK(focus_error, 7'h10)
		`CHK(radial_error, 7'h70)
		`CHK(satellite_error, 7'h00)
		axi_read(ofe_pkg::OFS_RADIAL_ERR, rd, resp);
		`CHK(rd, 32'hFFFF_FFF0)
		// laser on: stored offsets cancel the streams
		axi_write(ofe_pkg::OFS_LF_CTRL, 8'h20, 4'hF, resp);
		repeat (6 * WIN_CLK) @(posedge aclk);
		`CHK(focus_error, 7'h00)
		`CHK(radial_error, 7'h00)
		// aux audio steered onto the first two converters
		axi_write(ofe_pkg::OFS_LF_CTRL, 8'h30, 4'hF, resp);
		repeat (6 * WIN_CLK) @(posedge aclk);
		`CHK(focus_error, 7'h60)
		// second reset mid-run
		do_reset();
		for (int i = 0; i < 7; i++) begin
			axi_read(ADR_TAB[i], rd, resp);
			`CHK(rd, {24'h0, RST_TAB[i]})
		end
		`CHK(hf_power_down, 6'h3F)
		close_out();
	end
endmodule : optical_frontend_control_bench
